// File: hdl/bram_fifo_pkg.sv
// shared constants for the block-ram fifo datapath
package bram_fifo_pkg;
  localparam int MAX_W = 40;
  localparam int MAIN_W = 32;
  localparam int PAR_W = 4;
  localparam int LANE_W = 8;
  localparam int GRP10 = 10;
  localparam int GRP9 = 9;
  localparam int GRP10_XPAR = 9;
  localparam int GRP10_PAR = 4;
  localparam int GRP9_PAR = 8;
  localparam int FAM40 = 40;
  localparam int FAM36 = 36;
  localparam int FAM32 = 32;
  localparam int CAP_FAM40 = 20480;
  localparam int CAP_FAM36 = 18432;
  localparam int CAP_FAM32 = 16384;
  localparam int CNT_W = 16;
  localparam int PTR_W = 15;
  localparam int STAGE_DEPTH = 16;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [PTR_W-1:0] PTR_ZERO = 15'h0000;
  localparam logic [MAX_W-1:0] WORD_ZERO = 40'h00_0000_0000;
endpackage

// File: hdl/stage_fifo.sv
// small flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module stage_fifo #(
  parameter int WIDTH = 40,
  parameter int DEPTH = 16
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_clear,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign o_in_ready = (cnt_q != DEPTH[AW:0]);
  assign o_out_valid = (cnt_q != '0);
  assign o_out_data = mem_q[rd_q];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_q[wr_q] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else if (i_clear) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW + 1)'(push) - (AW + 1)'(pop);
    end
  end
endmodule
`default_nettype wire

// File: hdl/bram_fifo.sv
// block-ram style fifo datapath with width conversion and parity bus mapping
`timescale 1ns/1ps
`default_nettype none
// Function
// [RULE1] port widths one to forty, set independently
// [RULE2] integrator keeps both widths in one family
// [RULE3] encoder on: parity buses unused, code stored
// [RULE4] nine-bit groups: top bit on parity bus
// [RULE5] ten-bit groups: bits 9,4 on parity buses
// [RULE6] depth set by width without lookahead
// [RULE7] lookahead adds exactly one word of depth
// [RULE8] either pointer reset empties the buffer
// [RULE9] write stores word when not full
// [RULE10] full rises cycle after last free slot
// [RULE11] write when full dropped, error next cycle
// [RULE12] read presents next word when not empty
// [RULE13] words leave in write order, slot freed
// [RULE14] empty rises cycle after last word read
// [RULE15] read when empty fails, error next cycle
// [RULE16] write and read enable polarity selectors
// [RULE17] pointer reset polarity selectors
// [RULE18] encoder enable selects code or bypass
// [RULE19] width conversion is least significant first
module bram_fifo
  import bram_fifo_pkg::*;
#(
  parameter int WRITE_WIDTH = 40,
  parameter int READ_WIDTH = 40,
  parameter logic LOOKAHEAD = 1'b0,
  parameter logic WREN_ACTIVE = 1'b1,
  parameter logic RDEN_ACTIVE = 1'b1,
  parameter logic WRRST_ACTIVE = 1'b1,
  parameter logic RDRST_ACTIVE = 1'b1,
  parameter logic ENCODER_ENABLE = 1'b1
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_wr_ptr_rst,
  input wire logic i_rd_ptr_rst,
  input wire logic i_wr_en,
  input wire logic [MAIN_W-1:0] i_din,
  input wire logic [PAR_W-1:0] i_dinp,
  input wire logic [PAR_W-1:0] i_dinpx,
  input wire logic i_rd_en,
  output logic [MAIN_W-1:0] o_dout,
  output logic [PAR_W-1:0] o_doutp,
  output logic [PAR_W-1:0] o_doutpx,
  output logic o_full,
  output logic o_empty,
  output logic o_write_err,
  output logic o_read_err
);

  // width family of a port; crossing families is left to the integrator
  function automatic int family(input int w);
    if (w % 5 == 0) begin
      return FAM40;
    end else if (w % 9 == 0) begin
      return FAM36;
    end
    return FAM32;
  endfunction

  function automatic int capacity(input int w);
    if (family(w) == FAM40) begin
      return CAP_FAM40;
    end else if (family(w) == FAM36) begin
      return CAP_FAM36;
    end
    return CAP_FAM32;
  endfunction

  localparam int CAP = capacity(WRITE_WIDTH); // [RULE6]
  // lookahead keeps one read word outside the array
  localparam int TOTAL = CAP + (LOOKAHEAD ? READ_WIDTH : 0); // [RULE7]
  localparam logic [CNT_W-1:0] WW_C = CNT_W'(WRITE_WIDTH); // [RULE1]
  localparam logic [CNT_W-1:0] RW_C = CNT_W'(READ_WIDTH); // [RULE1]
  localparam logic [CNT_W-1:0] CAP_C = CNT_W'(CAP);
  localparam logic [CNT_W-1:0] TOTAL_C = CNT_W'(TOTAL);
  localparam logic [PTR_W-1:0] WW_P = PTR_W'(WRITE_WIDTH);
  localparam logic [PTR_W-1:0] RW_P = PTR_W'(READ_WIDTH);
  localparam logic [PTR_W-1:0] LAST_WR = PTR_W'(CAP - WRITE_WIDTH);
  localparam logic [PTR_W-1:0] LAST_RD = PTR_W'(CAP - READ_WIDTH);

  // main, parity and extended parity buses into one logical word
  function automatic logic [MAX_W-1:0] gather(
    input logic [MAIN_W-1:0] m,
    input logic [PAR_W-1:0] p,
    input logic [PAR_W-1:0] px
  );
    logic [MAX_W-1:0] d;
    int g;
    int k;
    d = WORD_ZERO;
    for (int b = 0; b < MAX_W; b++) begin
      if (b < WRITE_WIDTH) begin
        if (family(WRITE_WIDTH) == FAM40) begin
          g = b / GRP10;
          k = b % GRP10;
          if (k == GRP10_XPAR) begin
            d[b] = px[g]; // [RULE5]
          end else if (k == GRP10_PAR) begin
            d[b] = p[g]; // [RULE5]
          end else begin
            d[b] = m[g * LANE_W + ((k < GRP10_PAR) ? k : k - 1)]; // [RULE5]
          end
        end else if (family(WRITE_WIDTH) == FAM36) begin
          g = b / GRP9;
          k = b % GRP9;
          if (k == GRP9_PAR) begin
            d[b] = p[g]; // [RULE4]
          end else begin
            d[b] = m[g * LANE_W + k]; // [RULE4]
          end
        end else begin
          d[b] = m[b]; // [RULE4]
        end
      end
    end
    return d;
  endfunction

  // code bits: parity over the plain data bits of the same group half, or of the whole group when groups are nine bits
  function automatic logic [MAX_W-1:0] encode(input logic [MAX_W-1:0] din_w);
    logic [MAX_W-1:0] d;
    int g;
    int k;
    d = din_w;
    for (int b = 0; b < MAX_W; b++) begin
      if (b < WRITE_WIDTH && family(WRITE_WIDTH) == FAM40) begin
        g = b / GRP10;
        k = b % GRP10;
        if (k == GRP10_PAR) begin
          d[b] = 1'b0;
          for (int j = 0; j < GRP10_PAR; j++) begin
            d[b] = d[b] ^ din_w[g * GRP10 + j];
          end
        end else if (k == GRP10_XPAR && b < WRITE_WIDTH) begin
          d[b] = 1'b0;
          for (int j = GRP10_PAR + 1; j < GRP10_XPAR; j++) begin
            d[b] = d[b] ^ din_w[g * GRP10 + j];
          end
        end
      end else if (b < WRITE_WIDTH && family(WRITE_WIDTH) == FAM36) begin
        g = b / GRP9;
        k = b % GRP9;
        if (k == GRP9_PAR) begin
          d[b] = 1'b0;
          for (int j = 0; j < GRP9_PAR; j++) begin
            d[b] = d[b] ^ din_w[g * GRP9 + j];
          end
        end
      end
    end
    return d;
  endfunction

  // bus layout of one read-side word
  function automatic logic [MAIN_W + 2 * PAR_W - 1:0] scatter(input logic [MAX_W-1:0] d);
    logic [MAIN_W-1:0] m;
    logic [PAR_W-1:0] p;
    logic [PAR_W-1:0] px;
    int g;
    int k;
    m = '0;
    p = '0;
    px = '0;
    for (int b = 0; b < MAX_W; b++) begin
      if (b < READ_WIDTH) begin
        if (family(READ_WIDTH) == FAM40) begin
          g = b / GRP10;
          k = b % GRP10;
          if (k == GRP10_XPAR) begin
            px[g] = d[b]; // [RULE5]
          end else if (k == GRP10_PAR) begin
            p[g] = d[b]; // [RULE5]
          end else begin
            m[g * LANE_W + ((k < GRP10_PAR) ? k : k - 1)] = d[b]; // [RULE5]
          end
        end else if (family(READ_WIDTH) == FAM36) begin
          g = b / GRP9;
          k = b % GRP9;
          if (k == GRP9_PAR) begin
            p[g] = d[b]; // [RULE4]
          end else begin
            m[g * LANE_W + k] = d[b]; // [RULE4]
          end
        end else begin
          m[b] = d[b]; // [RULE4]
        end
      end
    end
    if (ENCODER_ENABLE) begin
      p = '0; // [RULE3]
      px = '0; // [RULE3]
    end
    return {px, p, m};
  endfunction

  logic wr_act;
  logic rd_act;
  logic ptr_clear;
  logic wr_ok;
  logic [MAX_W-1:0] wr_word;
  logic stage_in_ready;
  logic stage_out_valid;
  logic stage_out_ready;
  logic [MAX_W-1:0] stage_out_data;
  logic [CAP-1:0] mem_q;
  logic [PTR_W-1:0] wr_ptr_q;
  logic [PTR_W-1:0] rd_ptr_q;
  logic [CNT_W-1:0] total_q;
  logic [CNT_W-1:0] mem_cnt_q;
  logic [MAX_W-1:0] dout_q;
  logic ahead_valid_q;
  logic mem_has_word;
  logic mem_take;
  logic user_pop;
  logic [MAX_W-1:0] mem_word;
  logic [MAIN_W + 2 * PAR_W - 1:0] bus_out;
  logic write_err_q;
  logic read_err_q;

  assign wr_act = (i_wr_en == WREN_ACTIVE); // [RULE16]
  assign rd_act = (i_rd_en == RDEN_ACTIVE); // [RULE16]
  // either reset clears both sides since they share one clock
  assign ptr_clear = (i_wr_ptr_rst == WRRST_ACTIVE) || (i_rd_ptr_rst == RDRST_ACTIVE); // [RULE17]

  // full counts every stored bit, including staged and look-ahead words
  assign o_full = (total_q + WW_C > TOTAL_C) || !stage_in_ready; // [RULE10]
  assign wr_ok = wr_act && !o_full && !ptr_clear; // [RULE9]
  assign wr_word = ENCODER_ENABLE ? encode(gather(i_din, i_dinp, i_dinpx))
                                  : gather(i_din, i_dinp, i_dinpx); // [RULE18]

  // staging buffer between the write port and the array
  stage_fifo #(
    .WIDTH(MAX_W),
    .DEPTH(STAGE_DEPTH)
  ) u_stage (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_clear(ptr_clear),
    .i_in_valid(wr_ok),
    .o_in_ready(stage_in_ready),
    .i_in_data(wr_word),
    .o_out_valid(stage_out_valid),
    .i_out_ready(stage_out_ready),
    .o_out_data(stage_out_data)
  );

  assign stage_out_ready = (mem_cnt_q + WW_C <= CAP_C) && !ptr_clear;

  always_comb begin
    mem_word = WORD_ZERO;
    for (int i = 0; i < MAX_W; i++) begin
      if (i < READ_WIDTH) begin
        mem_word[i] = mem_q[PTR_W'(rd_ptr_q + PTR_W'(i))]; // [RULE19]
      end
    end
  end

  assign mem_has_word = (mem_cnt_q >= RW_C);
  // empty follows what the read side can see; staged words show a cycle later, or two cycles later with lookahead
  assign o_empty = LOOKAHEAD ? !ahead_valid_q : !mem_has_word; // [RULE14]
  assign user_pop = rd_act && !o_empty && !ptr_clear; // [RULE12]
  assign mem_take = LOOKAHEAD ? (mem_has_word && (!ahead_valid_q || user_pop) && !ptr_clear)
                              : user_pop;

  always_ff @(posedge i_clk) begin
    if (stage_out_valid && stage_out_ready) begin
      for (int i = 0; i < MAX_W; i++) begin
        if (i < WRITE_WIDTH) begin
          mem_q[PTR_W'(wr_ptr_q + PTR_W'(i))] <= stage_out_data[i]; // [RULE19]
        end
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wr_ptr_q <= PTR_ZERO;
    end else if (ptr_clear) begin
      wr_ptr_q <= PTR_ZERO; // [RULE8]
    end else if (stage_out_valid && stage_out_ready) begin
      wr_ptr_q <= (wr_ptr_q == LAST_WR) ? PTR_ZERO : wr_ptr_q + WW_P;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rd_ptr_q <= PTR_ZERO;
    end else if (ptr_clear) begin
      rd_ptr_q <= PTR_ZERO; // [RULE8]
    end else if (mem_take) begin
      rd_ptr_q <= (rd_ptr_q == LAST_RD) ? PTR_ZERO : rd_ptr_q + RW_P; // [RULE13]
    end
  end

  // array occupancy, used for draining and read readiness
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      mem_cnt_q <= CNT_ZERO;
    end else if (ptr_clear) begin
      mem_cnt_q <= CNT_ZERO; // [RULE8]
    end else begin
      mem_cnt_q <= mem_cnt_q + ((stage_out_valid && stage_out_ready) ? WW_C : CNT_ZERO)
                   - (mem_take ? RW_C : CNT_ZERO); // [RULE13]
    end
  end

  // whole occupancy as seen by the writer
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      total_q <= CNT_ZERO;
    end else if (ptr_clear) begin
      total_q <= CNT_ZERO; // [RULE8]
    end else begin
      total_q <= total_q + (wr_ok ? WW_C : CNT_ZERO) - (user_pop ? RW_C : CNT_ZERO); // [RULE10]
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ahead_valid_q <= 1'b0;
    end else if (ptr_clear || !LOOKAHEAD) begin
      ahead_valid_q <= 1'b0;
    end else if (mem_take) begin
      ahead_valid_q <= 1'b1;
    end else if (user_pop) begin
      ahead_valid_q <= 1'b0; // [RULE14]
    end
  end

  // a failed read leaves the output word untouched unless a lookahead prefetch loads it in the same cycle
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      dout_q <= WORD_ZERO;
    end else if (mem_take) begin
      dout_q <= mem_word; // [RULE12]
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      write_err_q <= 1'b0;
    end else begin
      write_err_q <= wr_act && o_full && !ptr_clear; // [RULE11]
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      read_err_q <= 1'b0;
    end else begin
      read_err_q <= rd_act && o_empty && !ptr_clear; // [RULE15]
    end
  end

  assign bus_out = scatter(dout_q);
  assign o_dout = bus_out[MAIN_W-1:0];
  assign o_doutp = bus_out[MAIN_W + PAR_W - 1:MAIN_W];
  assign o_doutpx = bus_out[MAIN_W + 2 * PAR_W - 1:MAIN_W + PAR_W];
  assign o_write_err = write_err_q;
  assign o_read_err = read_err_q;

endmodule
`default_nettype wire

// File: tb/fifo_checker_sva.sv
// port-level assertion checker for the block-ram fifo
`timescale 1ns/1ps
`default_nettype none
module fifo_checker
  import bram_fifo_pkg::*;
#(
  parameter logic WREN_ACTIVE = 1'b1,
  parameter logic RDEN_ACTIVE = 1'b1,
  parameter logic WRRST_ACTIVE = 1'b1,
  parameter logic RDRST_ACTIVE = 1'b1
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_wr_ptr_rst,
  input wire logic i_rd_ptr_rst,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire logic [MAIN_W-1:0] o_dout,
  input wire logic o_full,
  input wire logic o_empty,
  input wire logic o_write_err,
  input wire logic o_read_err
);
  logic prst;
  logic wr_act;
  logic rd_act;
  assign prst = (i_wr_ptr_rst == WRRST_ACTIVE) || (i_rd_ptr_rst == RDRST_ACTIVE);
  // a pointer reset swallows any request of its cycle
  assign wr_act = (i_wr_en == WREN_ACTIVE) && !prst;
  assign rd_act = (i_rd_en == RDEN_ACTIVE) && !prst;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  a_wr_err_set: assert property (wr_act && o_full |=> o_write_err)
    else $error("refused write gave no error");
  a_wr_err_cause: assert property (o_write_err |-> $past(wr_act && o_full))
    else $error("write error without refused write");
  a_rd_err_set: assert property (rd_act && o_empty |=> o_read_err)
    else $error("refused read gave no error");
  a_rd_err_cause: assert property (o_read_err |-> $past(rd_act && o_empty))
    else $error("read error without refused read");
  a_rd_fail_hold: assert property (rd_act && o_empty |=> $stable(o_dout))
    else $error("refused read moved read data");
  a_ptr_rst_empty: assert property (prst |=> o_empty && !o_full && !o_write_err && !o_read_err)
    else $error("pointer reset left fifo not empty");
  a_full_rise: assert property ($rose(o_full) |-> $past(wr_act))
    else $error("full rose without a write");
  a_full_hold: assert property (o_full && !rd_act && !prst |=> o_full)
    else $error("full dropped without a read");
  a_empty_rise: assert property ($rose(o_empty) |-> $past(rd_act) || $past(prst))
    else $error("empty rose without a read");
  a_dout_move: assert property (!$stable(o_dout) |-> $past(rd_act) || $past(prst))
    else $error("read data changed without a read");
  c_overflow: cover property (wr_act && o_full);
  c_underflow: cover property (rd_act && o_empty);
  c_ptr_rst: cover property (prst ##1 o_empty);
endmodule
bind bram_fifo fifo_checker #(.WREN_ACTIVE(WREN_ACTIVE), .RDEN_ACTIVE(RDEN_ACTIVE),
  .WRRST_ACTIVE(WRRST_ACTIVE), .RDRST_ACTIVE(RDRST_ACTIVE)) chk (.i_clk, .i_resetn, .i_wr_ptr_rst,
  .i_rd_ptr_rst, .i_wr_en, .i_rd_en, .o_dout, .o_full, .o_empty, .o_write_err, .o_read_err);
`default_nettype wire

// File: tb/fabric_model.sv
// fabric-side writer and reader model for the fifo ports
`timescale 1ns/1ps
`default_nettype none
module fabric_model
  import bram_fifo_pkg::*;
#(
  parameter logic WR_ACT = 1'b1,
  parameter logic RD_ACT = 1'b1
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_push,
  input wire logic i_pop,
  input wire logic i_force,
  input wire logic i_full,
  input wire logic i_empty,
  output logic o_wr_en,
  output logic o_rd_en,
  output logic [MAIN_W-1:0] o_din,
  output logic [PAR_W-1:0] o_dinp,
  output logic [PAR_W-1:0] o_dinpx,
  output logic [15:0] o_sent
);
  logic wr_go;
  logic tog_q;
  logic [15:0] sent_q;
  // overflow or underflow only when the bench forces it
  assign wr_go = i_push && (!i_full || i_force);
  assign o_wr_en = wr_go ? WR_ACT : !WR_ACT;
  assign o_rd_en = (i_pop && (!i_empty || i_force)) ? RD_ACT : !RD_ACT;
  // idle lines flip each cycle so a stray capture shows
  assign o_din = wr_go ? {sent_q ^ 16'ha5c3, sent_q} : {16{tog_q, !tog_q}};
  assign o_dinp = wr_go ? sent_q[3:0] ^ 4'h6 : {2{tog_q, !tog_q}};
  assign o_dinpx = {2{!tog_q, tog_q}};
  assign o_sent = sent_q;
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sent_q <= 16'h0000;
      tog_q <= 1'b0;
    end else begin
      tog_q <= !tog_q;
      if (wr_go && !i_full) begin
        sent_q <= sent_q + 16'h0001;
      end
    end
  end
endmodule
`default_nettype wire

// File: tb/tb_top.sv
// self-checking bench for the block-ram fifo datapath
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import bram_fifo_pkg::*;
;
  localparam int DEPTH = 512;
  logic clk, resetn, wr_ptr_rst, rd_ptr_rst, push, pop, force_err;
  logic wr_en, rd_en, full, empty, wr_err, rd_err;
  logic [MAIN_W-1:0] din, dout;
  logic [PAR_W-1:0] dinp, dinpx, doutp, doutpx;
  logic [15:0] sent, rd_idx;
  int miscompares, num_checks;
  bram_fifo #(
    .WRITE_WIDTH(36),
    .READ_WIDTH(36),
    .WREN_ACTIVE(1'b0),
    .ENCODER_ENABLE(1'b0)
  ) uut (.i_clk(clk), .i_resetn(resetn), .i_wr_ptr_rst(wr_ptr_rst), .i_rd_ptr_rst(rd_ptr_rst),
    .i_wr_en(wr_en), .i_din(din), .i_dinp(dinp), .i_dinpx(dinpx), .i_rd_en(rd_en), .o_dout(dout),
    .o_doutp(doutp), .o_doutpx(doutpx), .o_full(full), .o_empty(empty), .o_write_err(wr_err),
    .o_read_err(rd_err));
  fabric_model #(.WR_ACT(1'b0)) partner (.i_clk(clk), .i_resetn(resetn), .i_push(push),
    .i_pop(pop), .i_force(force_err), .i_full(full), .i_empty(empty), .o_wr_en(wr_en), .o_rd_en(rd_en),
    .o_din(din), .o_dinp(dinp), .o_dinpx(dinpx), .o_sent(sent));
  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic flag(input logic s, input logic e);
    check({39'h0, s}, {39'h0, e});
  endtask
  // parity bits ride as bits 35,26,17,8 on both sides
  function automatic logic [39:0] pat(input logic [15:0] n);
    return {4'h0, n[3:0] ^ 4'h6, n ^ 16'ha5c3, n};
  endfunction
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic wr_burst(input int n, input logic f);
    @(posedge clk);
    push <= 1'b1;
    force_err <= f;
    repeat (n - 1) @(posedge clk);
    @(posedge clk);
    push <= 1'b0;
    force_err <= 1'b0;
  endtask
  task automatic rd_burst(input int n);
    @(posedge clk);
    pop <= 1'b1;
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      if (i == n - 1) pop <= 1'b0;
      @(negedge clk);
      check({4'h0, doutp, dout}, pat(rd_idx));
      // extended parity bus is unused at width 36 while the partner toggles it
      check({36'h0, doutpx}, 40'h0);
      rd_idx++;
    end
  endtask
  task automatic try_rd();
    @(posedge clk);
    pop <= 1'b1;
    force_err <= 1'b1;
    @(posedge clk);
    pop <= 1'b0;
    force_err <= 1'b0;
    @(negedge clk);
  endtask
  task automatic wait_empty(input logic v);
    int k;
    k = 0;
    while (empty !== v && k < 20) begin
      @(negedge clk);
      k++;
    end
    if (empty !== v) begin
      miscompares++;
      conclude();
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    {wr_ptr_rst, rd_ptr_rst, push, pop, force_err, resetn} = 6'h00;
    rd_idx = 16'h0000;
    miscompares = 0;
    num_checks = 0;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    @(negedge clk);
    flag(empty, 1'b1);
    flag(full, 1'b0);
    try_rd();
    flag(rd_err, 1'b1);
    check({4'h0, doutp, dout}, 40'h0);
    $display("test underflow done");
    wr_burst(3, 1'b0);
    wait_empty(1'b0);
    rd_burst(3);
    flag(empty, 1'b1);
    $display("test order done");
    wr_burst(DEPTH - 1, 1'b0);
    @(negedge clk);
    flag(full, 1'b0);
    wr_burst(1, 1'b0);
    @(negedge clk);
    flag(full, 1'b1);
    wr_burst(1, 1'b1);
    @(negedge clk);
    flag(wr_err, 1'b1);
    // the error is a single-cycle pulse
    @(negedge clk);
    flag(wr_err, 1'b0);
    rd_burst(DEPTH);
    flag(empty, 1'b1);
    flag(full, 1'b0);
    $display("test fill done");
    for (int j = 0; j < 2; j++) begin
      wr_burst(4, 1'b0);
      wait_empty(1'b0);
      @(posedge clk);
      wr_ptr_rst <= (j == 0);
      rd_ptr_rst <= (j == 1);
      @(posedge clk);
      wr_ptr_rst <= 1'b0;
      rd_ptr_rst <= 1'b0;
      @(negedge clk);
      flag(empty, 1'b1);
      try_rd();
      flag(rd_err, 1'b1);
      rd_idx = sent;
      wr_burst(1, 1'b0);
      wait_empty(1'b0);
      rd_burst(1);
    end
    $display("test pointer reset done");
    conclude();
  end
endmodule
`default_nettype wire
